// ===== hdl/queued_spi_master_defines.vh
// Register map, field positions, reset values and limits of the queued serial master.
`ifndef QUEUED_SPI_MASTER_DEFINES_VH
`define QUEUED_SPI_MASTER_DEFINES_VH

// Byte offsets of the registers on the register bus.
`define QSM_OFF_MODE        12'h340
`define QSM_OFF_DELAY       12'h344
`define QSM_OFF_WRAP        12'h348
`define QSM_OFF_IRQ         12'h34c
`define QSM_OFF_INDEX       12'h350
`define QSM_OFF_WINDOW      12'h354

// Reset values.
`define QSM_MODE_RESET      16'h0104
`define QSM_DELAY_RESET     15'h0404

// Mode register fields.
`define QSM_MODE_BAUD_HI    7
`define QSM_MODE_BAUD_LO    0
`define QSM_MODE_CPHA       8
`define QSM_MODE_CPOL       9
`define QSM_MODE_BITS_HI    13
`define QSM_MODE_BITS_LO    10

// Delay register fields.
`define QSM_DLY_PRE_HI      7
`define QSM_DLY_PRE_LO      0
`define QSM_DLY_POST_HI     14
`define QSM_DLY_POST_LO     8
`define QSM_DLY_ENABLE      15

// Pointer and wrap register fields.
`define QSM_WRAP_ENABLE     15

// Interrupt register fields.
`define QSM_IRQ_FLAG        0
`define QSM_IRQ_ENABLE      8

// Local RAM internal addresses.
`define QSM_RAM_TX_BASE     6'h00
`define QSM_RAM_RX_BASE     6'h10
`define QSM_RAM_CMD_BASE    6'h20
`define QSM_RAM_TOP         6'h2f

// Command byte fields.
`define QSM_CMD_CONT        7
`define QSM_CMD_BITSE       6
`define QSM_CMD_POSTDLY     5
`define QSM_CMD_PREDLY      4

// Limits and idle values.
`define QSM_MIN_BAUD        8'h02
`define QSM_CS_IDLE         4'hf
`define QSM_BYTE_BITS       5'h08
`define QSM_FULL_BITS       5'h10

`endif

// ===== hdl/queued_spi_master.v
// Queued serial peripheral master with indirect RAM access over an Avalon-MM slave.
//
// Overview of operation
// - Run up to sixteen queued transfers unattended.
// - Transfer size eight to sixteen bits.
// - Four encoded selects address fifteen devices.
// - Clock divider spans 117.6 kbps to 15 Mbps.
// - Programmable delay before and after transfers.
// - Programmable clock polarity and phase.
// - Wrap option restarts queue continuously.
// - Master only, drives clock and selects.
// - Software sets queue start and end pointers.
// - Readable pointer to last executed entry.
// - Sixteen command bytes at 0x20 to 0x2F.
// - Sixteen transmit words at 0x00 to 0x0F.
// - Sixteen receive words at 0x10 to 0x1F.
// - RAM reached only through index and window.
// - Enable copies start pointer, then increments.
// - End entry done sets finish flag, interrupt.
// - Mode register sets size, divider, phase.
// - Delay register holds delays and enable.
// - Wrap register holds pointers and wrap control.
// - Interrupt register holds enable and flags.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`include "queued_spi_master_defines.vh"

module queued_spi_master
(
	// Clock and reset
	input  wire        i_ref_clk,
	input  wire        i_rst,
	// Avalon-MM register slave
	input  wire [11:0] i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	// Serial link
	output reg         o_sclk,
	output reg         o_mosi,
	input  wire        i_miso,
	output reg  [3:0]  o_cs_code,
	// Finish interrupt
	output reg         o_irq
);

	// Engine states.
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_LOAD = 3'h1;
	localparam [2:0] S_PRE  = 3'h2;
	localparam [2:0] S_XFER = 3'h3;
	localparam [2:0] S_POST = 3'h4;
	localparam [2:0] S_NEXT = 3'h5;

	// Local RAM.
	reg  [15:0] tx_ram  [0:15];
	reg  [15:0] rx_ram  [0:15];
	reg  [7:0]  cmd_ram [0:15];

	// Software visible state.
	reg  [15:0] mode_cfg;
	reg  [14:0] dly_cfg;
	reg         engine_en;
	reg  [3:0]  queue_start_ptr;
	reg  [3:0]  queue_end_ptr;
	reg  [3:0]  queue_done_ptr;
	reg         wrap_en;
	reg         irq_en;
	reg         queue_finish_flag;
	reg  [5:0]  ram_idx;

	// Engine state.
	reg  [2:0]  state;
	reg  [3:0]  work_ptr;
	reg  [7:0]  cmd_q;
	reg  [15:0] shift_tx;
	reg  [15:0] shift_rx;
	reg  [4:0]  bit_cnt;
	reg  [7:0]  half_cnt;
	reg         second_half;
	reg  [7:0]  dly_cnt;
	reg         miso_meta;
	reg         miso_sync;

	// Combinational helpers.
	reg  [31:0] rd_mux;
	reg  [15:0] win_rd;
	wire [11:0] word_addr;
	wire        bus_hit;
	wire        bus_wr;
	wire        bus_rd;
	wire [15:0] wd;
	wire [1:0]  be;
	wire        win_access;
	wire [15:0] dly_merged;
	wire [7:0]  baud_eff;
	wire        cpha;
	wire        cpol;
	wire [7:0]  load_cmd;
	wire [4:0]  load_bits;
	wire        at_end;
	wire        finish_set;
	wire        hw_stop;

	// Byte-lane merge for 16-bit registers.
	function [15:0] merge16;
		input [15:0] old_v;
		input [15:0] new_v;
		input [1:0]  lanes;
		begin
			merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8],
				lanes[0] ? new_v[7:0] : old_v[7:0]};
		end
	endfunction

	// Bit count of one entry: eight unless the command asks for the mode size.
	function [4:0] xfer_bits;
		input [7:0] cmd;
		input [3:0] code;
		begin
			if (!cmd[`QSM_CMD_BITSE])
				xfer_bits = `QSM_BYTE_BITS;
			else if (code < 4'h8)
				xfer_bits = `QSM_FULL_BITS;
			else
				xfer_bits = {1'b0, code};
		end
	endfunction

	// Bus decode; an access completes in the cycle that waitrequest is low.
	assign word_addr  = {i_avs_address[11:2], 2'b00};
	assign bus_hit    = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
	assign bus_wr     = bus_hit & i_avs_write;
	assign bus_rd     = bus_hit & i_avs_read;
	assign wd         = i_avs_writedata[15:0];
	assign be         = i_avs_byteenable[1:0];
	assign win_access = bus_hit & (word_addr == `QSM_OFF_WINDOW);
	assign dly_merged = merge16({engine_en, dly_cfg}, wd, be);

	// Serial timing settings; divider floor keeps the half period at two clocks.
	assign baud_eff  = (mode_cfg[`QSM_MODE_BAUD_HI:`QSM_MODE_BAUD_LO] < `QSM_MIN_BAUD) ?
		`QSM_MIN_BAUD : mode_cfg[`QSM_MODE_BAUD_HI:`QSM_MODE_BAUD_LO];
	assign cpha      = mode_cfg[`QSM_MODE_CPHA];
	assign cpol      = mode_cfg[`QSM_MODE_CPOL];
	assign load_cmd  = cmd_ram[work_ptr];
	assign load_bits = xfer_bits(load_cmd,
		mode_cfg[`QSM_MODE_BITS_HI:`QSM_MODE_BITS_LO]);

	// Queue end detection.
	assign at_end     = (work_ptr == queue_end_ptr);
	assign finish_set = (state == S_NEXT) & at_end;
	assign hw_stop    = finish_set & ~wrap_en;

	// Window read path into the three RAM segments.
	always @*
	begin
		win_rd = 16'h0000;
		if (ram_idx < `QSM_RAM_RX_BASE)
			win_rd = tx_ram[ram_idx[3:0]];
		else if (ram_idx < `QSM_RAM_CMD_BASE)
			win_rd = rx_ram[ram_idx[3:0]];
		else if (ram_idx <= `QSM_RAM_TOP)
			win_rd = {8'h00, cmd_ram[ram_idx[3:0]]};
	end

	// Register read multiplexer; unmapped words read as zero.
	always @*
	begin
		rd_mux = 32'h00000000;
		case (word_addr)
			`QSM_OFF_MODE:   rd_mux = {16'h0000, mode_cfg};
			`QSM_OFF_DELAY:  rd_mux = {16'h0000, engine_en, dly_cfg};
			`QSM_OFF_WRAP:   rd_mux = {16'h0000, wrap_en, 3'h0, queue_end_ptr,
				queue_done_ptr, queue_start_ptr};
			`QSM_OFF_IRQ:    rd_mux = {16'h0000, 7'h00, irq_en, 7'h00,
				queue_finish_flag};
			`QSM_OFF_INDEX:  rd_mux = {26'h0, ram_idx};
			`QSM_OFF_WINDOW: rd_mux = {16'h0000, win_rd};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	// Avalon handshake: one wait cycle, then waitrequest low for one cycle.
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h00000000;
		end
		else if ((i_avs_read | i_avs_write) & o_avs_waitrequest)
		begin
			o_avs_waitrequest <= 1'b0;
			o_avs_readdata    <= rd_mux;
		end
		else
		begin
			o_avs_waitrequest <= 1'b1;
		end
	end

	// Software registers; a hardware set of the finish flag beats a clear.
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			mode_cfg          <= `QSM_MODE_RESET;
			dly_cfg           <= `QSM_DELAY_RESET;
			engine_en         <= 1'b0;
			queue_start_ptr   <= 4'h0;
			queue_end_ptr     <= 4'h0;
			wrap_en           <= 1'b0;
			irq_en            <= 1'b0;
			queue_finish_flag <= 1'b0;
			ram_idx           <= 6'h00;
			o_irq             <= 1'b0;
		end
		else
		begin
			if (bus_wr && word_addr == `QSM_OFF_MODE)
				mode_cfg <= merge16(mode_cfg, wd, be);
			if (bus_wr && word_addr == `QSM_OFF_DELAY)
			begin
				dly_cfg   <= dly_merged[14:0];
				engine_en <= dly_merged[`QSM_DLY_ENABLE];
			end
			else if (hw_stop)
				engine_en <= 1'b0;
			if (bus_wr && word_addr == `QSM_OFF_WRAP)
			begin
				if (be[0])
					queue_start_ptr <= wd[3:0];
				if (be[1])
				begin
					queue_end_ptr <= wd[11:8];
					wrap_en       <= wd[`QSM_WRAP_ENABLE];
				end
			end
			if (bus_wr && word_addr == `QSM_OFF_IRQ && be[1])
				irq_en <= wd[`QSM_IRQ_ENABLE];
			if (finish_set)
				queue_finish_flag <= 1'b1;
			else if (bus_wr && word_addr == `QSM_OFF_IRQ && be[0] && wd[`QSM_IRQ_FLAG])
				queue_finish_flag <= 1'b0;
			if (bus_wr && word_addr == `QSM_OFF_INDEX && be[0])
				ram_idx <= wd[5:0];
			else if (win_access)
				ram_idx <= ram_idx + 6'h01;
			o_irq <= queue_finish_flag & irq_en;
		end
	end

	// RAM writes: software through the window, the engine stores receive words.
	always @(posedge i_ref_clk)
	begin
		if (win_access && i_avs_write)
		begin
			if (ram_idx < `QSM_RAM_RX_BASE)
				tx_ram[ram_idx[3:0]] <= merge16(tx_ram[ram_idx[3:0]], wd, be);
			else if (ram_idx < `QSM_RAM_CMD_BASE)
				rx_ram[ram_idx[3:0]] <= merge16(rx_ram[ram_idx[3:0]], wd, be);
			else if (ram_idx <= `QSM_RAM_TOP && be[0])
				cmd_ram[ram_idx[3:0]] <= wd[7:0];
		end
		if (state == S_NEXT)
			rx_ram[work_ptr] <= shift_rx;
	end

	// Input synchroniser for the serial data line.
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			miso_meta <= 1'b0;
			miso_sync <= 1'b0;
		end
		else
		begin
			miso_meta <= i_miso;
			miso_sync <= miso_meta;
		end
	end

	// Queue engine: load entry, delay, shift bits, delay, store and advance.
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state          <= S_IDLE;
			work_ptr       <= 4'h0;
			cmd_q          <= 8'h00;
			shift_tx       <= 16'h0000;
			shift_rx       <= 16'h0000;
			bit_cnt        <= 5'h00;
			half_cnt       <= 8'h00;
			second_half    <= 1'b0;
			dly_cnt        <= 8'h00;
			queue_done_ptr <= 4'h0;
			o_sclk         <= 1'b0;
			o_mosi         <= 1'b0;
			o_cs_code      <= `QSM_CS_IDLE;
		end
		else
		begin
			case (state)
				S_IDLE:
				begin
					o_sclk    <= cpol;
					o_cs_code <= `QSM_CS_IDLE;
					if (engine_en)
					begin
						work_ptr <= queue_start_ptr;
						state    <= S_LOAD;
					end
				end
				S_LOAD:
				begin
					cmd_q     <= load_cmd;
					shift_tx  <= tx_ram[work_ptr] << (`QSM_FULL_BITS - load_bits);
					bit_cnt   <= load_bits;
					shift_rx  <= 16'h0000;
					o_cs_code <= load_cmd[3:0];
					dly_cnt   <= load_cmd[`QSM_CMD_PREDLY] ?
						dly_cfg[`QSM_DLY_PRE_HI:`QSM_DLY_PRE_LO] : 8'h00;
					state     <= S_PRE;
				end
				S_PRE:
				begin
					if (dly_cnt != 8'h00)
						dly_cnt <= dly_cnt - 8'h01;
					else
					begin
						o_mosi      <= shift_tx[15];
						o_sclk      <= cpol ^ cpha;
						half_cnt    <= baud_eff - 8'h01;
						second_half <= 1'b0;
						state       <= S_XFER;
					end
				end
				S_XFER:
				begin
					if (half_cnt != 8'h00)
						half_cnt <= half_cnt - 8'h01;
					else
					begin
						half_cnt <= baud_eff - 8'h01;
						if (!second_half)
						begin
							second_half <= 1'b1;
							o_sclk      <= ~o_sclk;
						end
						else
						begin
							// Data is taken at the end of each bit, after sync delay.
							second_half <= 1'b0;
							shift_rx    <= {shift_rx[14:0], miso_sync};
							shift_tx    <= {shift_tx[14:0], 1'b0};
							bit_cnt     <= bit_cnt - 5'h01;
							if (bit_cnt == 5'h01)
							begin
								o_sclk  <= cpol;
								dly_cnt <= cmd_q[`QSM_CMD_POSTDLY] ?
									{1'b0, dly_cfg[`QSM_DLY_POST_HI:`QSM_DLY_POST_LO]} :
									8'h00;
								state   <= S_POST;
							end
							else
							begin
								o_sclk <= ~o_sclk;
								o_mosi <= shift_tx[14];
							end
						end
					end
				end
				S_POST:
				begin
					if (dly_cnt != 8'h00)
						dly_cnt <= dly_cnt - 8'h01;
					else
						state <= S_NEXT;
				end
				S_NEXT:
				begin
					// Receive word lands in RAM at this same edge.
					queue_done_ptr <= work_ptr;
					if (!cmd_q[`QSM_CMD_CONT])
						o_cs_code <= `QSM_CS_IDLE;
					if (at_end && wrap_en && engine_en)
					begin
						work_ptr <= queue_start_ptr;
						state    <= S_LOAD;
					end
					else if (at_end || !engine_en)
					begin
						o_cs_code <= `QSM_CS_IDLE;
						state     <= S_IDLE;
					end
					else
					begin
						work_ptr <= work_ptr + 4'h1;
						state    <= S_LOAD;
					end
				end
				default:
				begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== tb/spi_peripheral_model.sv
// Behavioural serial peripheral that shifts out a reply and records what it hears.
`timescale 1ns/1ps

module spi_peripheral_model
(
	// Link pins
	input  wire        i_sclk,
	input  wire        i_mosi,
	input  wire [3:0]  i_cs_code,
	output reg         o_miso,
	// Setup and results
	input  wire        i_cpol,
	input  wire        i_cpha,
	input  wire [15:0] i_reply,
	output reg  [15:0] o_got
);
	reg [15:0] shift;
	reg [3:0]  last_cs;
	reg        last_sclk;

	// Known start values.
	initial
	begin
		o_miso = 1'b0;
		o_got = 16'h0000;
		shift = 16'h0000;
		last_cs = 4'hf;
		last_sclk = 1'b0;
	end

	// A select change reloads the reply and a deselected line drifts to the inverse.
	// Otherwise each clock edge either samples the master or presents the next bit.
	always @(i_cs_code or i_sclk)
	begin
		if (i_cs_code !== last_cs)
		begin
			shift = i_reply;
			if (i_cs_code == 4'hf)
				o_miso = ~o_miso;
			else if (!i_cpha)
			begin
				o_miso = shift[15];
				shift = shift << 1;
			end
		end
		else if (i_sclk !== last_sclk && i_cs_code != 4'hf)
		begin
			if ((i_sclk != i_cpol) ^ i_cpha)
				o_got = {o_got[14:0], i_mosi};
			else
			begin
				o_miso = shift[15];
				shift = shift << 1;
			end
		end
		last_cs = i_cs_code;
		last_sclk = i_sclk;
	end
endmodule

// ===== tb/queued_spi_master_properties.sv
// Port-level checks for the queued serial master and the bind that attaches them.
`timescale 1ns/1ps

module queued_spi_master_properties
(
	// Clock, reset and register bus
	input wire        i_ref_clk,
	input wire        i_rst,
	input wire [11:0] i_avs_address,
	input wire        i_avs_read,
	input wire        i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [31:0] o_avs_readdata,
	input wire        o_avs_waitrequest,
	// Serial link and interrupt
	input wire        o_sclk,
	input wire        o_mosi,
	input wire [3:0]  o_cs_code,
	input wire        o_irq
);
	// Every check samples on the bus clock and rests during reset.
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// Pending request, answer, and a write that masks the interrupt.
	wire req = i_avs_read | i_avs_write;
	wire ack = !o_avs_waitrequest;
	wire irq_off = ack && i_avs_write && i_avs_address == 12'h34c && !i_avs_writedata[8];

	a_wait_answer: assert property (req && !ack |=> ack)
		else $error("no answer after one wait cycle");
	a_wait_single: assert property (ack |=> !ack)
		else $error("answer lasted over one cycle");
	a_wait_unasked: assert property (!req && !ack |=> !ack)
		else $error("answer without request");
	a_read_high: assert property (ack |-> o_avs_readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_unmapped_zero: assert property (ack && i_avs_read && i_avs_address[11:8] != 4'h3 |->
		o_avs_readdata == 32'h0) else $error("unmapped read not zero");
	a_irq_masked: assert property (irq_off |=> ##1 !o_irq)
		else $error("interrupt stayed up after masking");
	a_sclk_framed: assert property ($changed(o_sclk) |-> o_cs_code != 4'hf ||
		$past(i_avs_write) || $past(i_avs_write, 2) || $past(i_avs_write, 3))
		else $error("serial clock moved while nobody selected");
	a_cs_holds: assert property (o_cs_code != 4'hf && $past(o_cs_code) == 4'hf |=>
		$stable(o_cs_code)[*8]) else $error("select dropped too early");
	a_mosi_bits: assert property ($changed(o_mosi) && o_cs_code != 4'hf |=>
		$stable(o_mosi)[*3]) else $error("data bit shorter than four cycles");
endmodule

bind queued_spi_master queued_spi_master_properties u_props
(
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_sclk(o_sclk), .o_mosi(o_mosi), .o_cs_code(o_cs_code), .o_irq(o_irq)
);

// ===== tb/queued_spi_master_tb.sv
// Self-checking bench for the queued serial master against a peripheral model.
`timescale 1ns/1ps

module queued_spi_master_tb;
	reg         i_ref_clk, i_rst, i_avs_read, i_avs_write, cpol, cpha;
	reg  [11:0] i_avs_address;
	reg  [31:0] i_avs_writedata;
	reg  [15:0] q;
	reg  [43:0] rows [0:5];
	wire [31:0] o_avs_readdata;
	wire        o_avs_waitrequest, o_sclk, o_mosi, i_miso, o_irq;
	wire [3:0]  o_cs_code;
	wire [15:0] got;
	integer     num_errors, check_count, cyc, i, m, sel_cnt;

	// Device under test and the peripheral on its link.
	queued_spi_master u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'h3),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.o_sclk(o_sclk), .o_mosi(o_mosi), .i_miso(i_miso), .o_cs_code(o_cs_code), .o_irq(o_irq));
	spi_peripheral_model u_peer (.i_sclk(o_sclk), .i_mosi(o_mosi), .i_cs_code(o_cs_code),
		.o_miso(i_miso), .i_cpol(cpol), .i_cpha(cpha), .i_reply(16'hb4c3), .o_got(got));

	// Free-running 100 MHz clock.
	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// A hung run is cut short and counted as a mismatch; edges with select 1 are counted.
	always @(posedge i_ref_clk)
	begin
		cyc = cyc + 1;
		if (o_cs_code == 4'h1)
			sel_cnt = sel_cnt + 1;
		if (cyc == 10000)
		begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: timeout", $time);
			close_out;
		end
	end

	// Transmit word and command byte of each queue slot.
	function [15:0] txw(input [3:0] k);
		txw = {k, ~k, 4'h9, k};
	endfunction
	function [7:0] cmdb(input [3:0] k);
		cmdb = {1'b0, k != 4'h2, k[0], k[0], (k == 4'hf) ? 4'h0 : k};
	endfunction

	// One register access, held until the answer, then released for a cycle.
	task acc(input wr, input [11:0] a, input [15:0] d);
		begin
			i_avs_address <= a;
			i_avs_writedata <= {16'h0000, d};
			i_avs_write <= wr;
			i_avs_read <= !wr;
			@(posedge i_ref_clk);
			while (o_avs_waitrequest !== 1'b0)
				@(posedge i_ref_clk);
			q = o_avs_readdata[15:0];
			i_avs_write <= 1'b0;
			i_avs_read <= 1'b0;
			@(posedge i_ref_clk);
		end
	endtask

	// Compares one 16-bit result.
	task chk(input [15:0] g, input [15:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e)
			begin
				num_errors = num_errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task close_out;
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	// Holds reset for six cycles.
	task do_reset;
		begin
			i_rst <= 1'b1;
			repeat (6) @(posedge i_ref_clk);
			i_rst <= 1'b0;
			@(posedge i_ref_clk);
		end
	endtask

	// Runs the queue from s to e and waits for the finish interrupt.
	task run(input [3:0] s, input [3:0] e, input w);
		integer n;
		begin
			n = 0;
			sel_cnt = 0;
			acc(1, 12'h348, {w, 3'b000, e, 4'h0, s});
			acc(1, 12'h34c, 16'h0101);
			acc(1, 12'h344, 16'h8201);
			while (o_irq !== 1'b1 && n < 3000)
			begin
				@(posedge i_ref_clk);
				n = n + 1;
			end
			chk({15'h0000, o_irq}, 16'h0001);
		end
	endtask

	// Main sequence.
	initial
	begin
		i_rst = 1'b1;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_address = 12'h000;
		i_avs_writedata = 32'h0;
		cpol = 1'b0;
		cpha = 1'b0;
		num_errors = 0;
		check_count = 0;
		cyc = 0;
		sel_cnt = 0;
		rows[0] = {12'h340, 16'h2b05, 16'h2b05};
		rows[1] = {12'h344, 16'h0302, 16'h0302};
		rows[2] = {12'h348, 16'h0a53, 16'h0a03};
		rows[3] = {12'h34c, 16'h0100, 16'h0100};
		rows[4] = {12'h350, 16'h0025, 16'h0025};
		rows[5] = {12'h058, 16'hffff, 16'h0000};
		do_reset;
		for (i = 0; i < 6; i = i + 1)
		begin
			acc(1, rows[i][43:32], rows[i][31:16]);
			acc(0, rows[i][43:32], 16'h0000);
			chk(q, rows[i][15:0]);
		end
		do_reset;
		for (i = 0; i < 5; i = i + 1)
		begin
			acc(0, {i[9:0], 2'b00} + 12'h340, 16'h0000);
			chk(q, (i == 0) ? 16'h0104 : (i == 1) ? 16'h0404 : 16'h0000);
		end
		acc(1, 12'h350, 16'h0000);
		for (i = 0; i < 16; i = i + 1)
			acc(1, 12'h354, txw(i[3:0]));
		acc(1, 12'h350, 16'h0020);
		for (i = 0; i < 16; i = i + 1)
			acc(1, 12'h354, {8'h00, cmdb(i[3:0])});
		acc(1, 12'h350, 16'h0025);
		acc(0, 12'h354, 16'h0000);
		chk({8'h00, q[7:0]}, {8'h00, cmdb(4'h5)});
		acc(1, 12'h350, 16'h0005);
		acc(0, 12'h354, 16'h0000);
		chk(q, txw(4'h5));
		for (m = 0; m < 4; m = m + 1)
		begin
			cpol = m[1];
			cpha = m[0];
			acc(1, 12'h340, {2'b00, 4'hc, m[1], m[0], 8'h03});
			run(4'h0, 4'h2, 1'b0);
			chk(sel_cnt[15:0], 16'h004e);
			acc(0, 12'h348, 16'h0000);
			chk(q, 16'h0220);
			acc(0, 12'h344, 16'h0000);
			chk(q & 16'h8000, 16'h0000);
			chk(got, (txw(4'h1) << 8) | (txw(4'h2) & 16'h00ff));
			acc(1, 12'h350, 16'h0010);
			for (i = 0; i < 3; i = i + 1)
			begin
				acc(0, 12'h354, 16'h0000);
				chk(q, (i == 2) ? 16'h00b4 : 16'h0b4c);
			end
		end
		run(4'he, 4'h1, 1'b1);
		acc(0, 12'h344, 16'h0000);
		chk(q & 16'h8000, 16'h8000);
		acc(1, 12'h344, 16'h0201);
		repeat (400) @(posedge i_ref_clk);
		chk({12'h000, o_cs_code}, 16'h000f);
		acc(1, 12'h350, 16'h001f);
		acc(0, 12'h354, 16'h0000);
		chk(q, 16'h0b4c);
		acc(1, 12'h34c, 16'h0000);
		acc(0, 12'h34c, 16'h0000);
		chk(q, 16'h0001);
		chk({15'h0000, o_irq}, 16'h0000);
		close_out;
	end
endmodule
